// file: rtl/rds_map.svh
`ifndef RDS_MAP_SVH
`define RDS_MAP_SVH
`define RDS_OFS_OWN 2'h0
`define RDS_OFS_RATE 2'h1
`define RDS_OFS_STAT 2'h2
`define RDS_OWN_RST 8'h00
`define RDS_RATE_RST 8'h00
`define RDS_CODE_HI 5
`define RDS_CODE_LO 0
`define RDS_MUL_HI 7
`define RDS_MUL_LO 6
`define RDS_ADR_HI 7
`define RDS_ADR_LO 1
`define RDS_MUL_X1 2'h0
`define RDS_MUL_X2 2'h1
`define RDS_MUL_X4 2'h2
`define RDS_PRE_X1 2'h0
`define RDS_PRE_X2 2'h1
`define RDS_PRE_X4 2'h3
`define RDS_PRE_ZERO 2'h0
`define RDS_PRE_ONE 2'h1
`define RDS_CNT_ZERO 12'h000
`define RDS_CNT_ONE 12'h001
`define RDS_DIV_00 12'h014
`define RDS_DIV_3F 12'hf00
`define RDS_CODE_00 6'h00
`define RDS_CODE_3F 6'h3f
`endif

// file: rtl/rds_pkg.sv
package rds_pkg;
  typedef struct packed {
    logic [11:0] div;
    logic [9:0] sda_hold;
    logic [10:0] start_hold;
    logic [10:0] stop_hold;
  } rds_rate_s;
  typedef enum logic [1:0] {
    RDS_CMD_START,
    RDS_CMD_BIT,
    RDS_CMD_STOP,
    RDS_CMD_NONE
  } rds_cmd_e;
  typedef enum logic [2:0] {
    S_IDLE,
    S_RS_LO,
    S_RS_HI,
    S_ST_HOLD,
    S_BIT_LO,
    S_BIT_HI,
    S_SP_LO,
    S_SP_HI
  } rds_state_e;
endpackage

// file: rtl/rds_rate_addr.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "rds_map.svh"
// What this block does
// RL1: Clock line driven low or sensed, open drain
// RL2: Data line driven low or sensed, open drain
// RL3: Match incoming address against own address bits
// RL4: Six-bit code sets divider, selects hold values
// RL5: Bit rate is clock over multiplier times divider
// RL6: Data changes only after clock fall, hold delay
// RL7: Start: data low, wait start hold, clock low
// RL8: Stop: release clock, wait stop hold, data rises
// RL9: Each code decodes to divider and three holds
// RL10: Codes 00 to 1F follow table exactly
// RL11: Codes 20 to 3F continue the table
// RL12: Multiplier field picks one, two or four
module rds_rate_addr import rds_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmd_valid,
  input wire rds_cmd_e cmd,
  input wire logic cmd_bit,
  output logic cmd_ready,
  output logic done,
  output logic rx_bit,
  input wire logic addr_valid,
  input wire logic [6:0] addr_in,
  output logic addr_match,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  function automatic rds_rate_s rds_lookup(input logic [5:0] c);
    rds_rate_s r;
    case (c) // RL9 RL10 RL11
      6'h00: r = '{12'h014, 10'h007, 11'h006, 11'h00b};
      6'h01: r = '{12'h016, 10'h007, 11'h007, 11'h00c};
      6'h02: r = '{12'h018, 10'h008, 11'h008, 11'h00d};
      6'h03: r = '{12'h01a, 10'h008, 11'h009, 11'h00e};
      6'h04: r = '{12'h01c, 10'h009, 11'h00a, 11'h00f};
      6'h05: r = '{12'h01e, 10'h009, 11'h00b, 11'h010};
      6'h06: r = '{12'h022, 10'h00a, 11'h00d, 11'h012};
      6'h07: r = '{12'h028, 10'h00a, 11'h010, 11'h015};
      6'h08: r = '{12'h01c, 10'h007, 11'h00a, 11'h00f};
      6'h09: r = '{12'h020, 10'h007, 11'h00c, 11'h011};
      6'h0a: r = '{12'h024, 10'h009, 11'h00e, 11'h013};
      6'h0b: r = '{12'h028, 10'h009, 11'h010, 11'h015};
      6'h0c: r = '{12'h02c, 10'h00b, 11'h012, 11'h017};
      6'h0d: r = '{12'h030, 10'h00b, 11'h014, 11'h019};
      6'h0e: r = '{12'h038, 10'h00d, 11'h018, 11'h01d};
      6'h0f: r = '{12'h044, 10'h00d, 11'h01e, 11'h023};
      6'h10: r = '{12'h030, 10'h009, 11'h012, 11'h019};
      6'h11: r = '{12'h038, 10'h009, 11'h016, 11'h01d};
      6'h12: r = '{12'h040, 10'h00d, 11'h01a, 11'h021};
      6'h13: r = '{12'h048, 10'h00d, 11'h01e, 11'h025};
      6'h14: r = '{12'h050, 10'h011, 11'h022, 11'h029};
      6'h15: r = '{12'h058, 10'h011, 11'h026, 11'h02d};
      6'h16: r = '{12'h068, 10'h015, 11'h02e, 11'h035};
      6'h17: r = '{12'h080, 10'h015, 11'h03a, 11'h041};
      6'h18: r = '{12'h050, 10'h009, 11'h026, 11'h029};
      6'h19: r = '{12'h060, 10'h009, 11'h02e, 11'h031};
      6'h1a: r = '{12'h070, 10'h011, 11'h036, 11'h039};
      6'h1b: r = '{12'h080, 10'h011, 11'h03e, 11'h041};
      6'h1c: r = '{12'h090, 10'h019, 11'h046, 11'h049};
      6'h1d: r = '{12'h0a0, 10'h019, 11'h04e, 11'h051};
      6'h1e: r = '{12'h0c0, 10'h021, 11'h05e, 11'h061};
      6'h1f: r = '{12'h0f0, 10'h021, 11'h076, 11'h079};
      6'h20: r = '{12'h0a0, 10'h011, 11'h04e, 11'h051};
      6'h21: r = '{12'h0c0, 10'h011, 11'h05e, 11'h061};
      6'h22: r = '{12'h0e0, 10'h021, 11'h06e, 11'h071};
      6'h23: r = '{12'h100, 10'h021, 11'h07e, 11'h081};
      6'h24: r = '{12'h120, 10'h031, 11'h08e, 11'h091};
      6'h25: r = '{12'h140, 10'h031, 11'h09e, 11'h0a1};
      6'h26: r = '{12'h180, 10'h041, 11'h0be, 11'h0c1};
      6'h27: r = '{12'h1e0, 10'h041, 11'h0ee, 11'h0f1};
      6'h28: r = '{12'h140, 10'h021, 11'h09e, 11'h0a1};
      6'h29: r = '{12'h180, 10'h021, 11'h0be, 11'h0c1};
      6'h2a: r = '{12'h1c0, 10'h041, 11'h0de, 11'h0e1};
      6'h2b: r = '{12'h200, 10'h041, 11'h0fe, 11'h101};
      6'h2c: r = '{12'h240, 10'h061, 11'h11e, 11'h121};
      6'h2d: r = '{12'h280, 10'h061, 11'h13e, 11'h141};
      6'h2e: r = '{12'h300, 10'h081, 11'h17e, 11'h181};
      6'h2f: r = '{12'h3c0, 10'h081, 11'h1de, 11'h1e1};
      6'h30: r = '{12'h280, 10'h041, 11'h13e, 11'h141};
      6'h31: r = '{12'h300, 10'h041, 11'h17e, 11'h181};
      6'h32: r = '{12'h380, 10'h081, 11'h1be, 11'h1c1};
      6'h33: r = '{12'h400, 10'h081, 11'h1fe, 11'h201};
      6'h34: r = '{12'h480, 10'h0c1, 11'h23e, 11'h241};
      6'h35: r = '{12'h500, 10'h0c1, 11'h27e, 11'h281};
      6'h36: r = '{12'h600, 10'h101, 11'h2fe, 11'h301};
      6'h37: r = '{12'h780, 10'h101, 11'h3be, 11'h3c1};
      6'h38: r = '{12'h500, 10'h081, 11'h27e, 11'h281};
      6'h39: r = '{12'h600, 10'h081, 11'h2fe, 11'h301};
      6'h3a: r = '{12'h700, 10'h101, 11'h37e, 11'h381};
      6'h3b: r = '{12'h800, 10'h101, 11'h3fe, 11'h401};
      6'h3c: r = '{12'h900, 10'h181, 11'h47e, 11'h481};
      6'h3d: r = '{12'ha00, 10'h181, 11'h4fe, 11'h501};
      6'h3e: r = '{12'hc00, 10'h201, 11'h5fe, 11'h601};
      default: r = '{12'hf00, 10'h201, 11'h77e, 11'h781};
    endcase
    return r;
  endfunction

  logic [7:0] own_ff, nxt_own;
  logic [7:0] rate_ff, nxt_rate;
  logic [7:0] rdata_ff, nxt_rdata;
  logic match_ff, nxt_match;
  rds_state_e state_ff, nxt_state;
  logic [1:0] pre_ff, nxt_pre;
  logic [11:0] cnt_ff, nxt_cnt;
  logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic bit_ff, nxt_bit, rx_ff, nxt_rx, done_ff, nxt_done;
  rds_rate_s rate_e;
  logic [1:0] pre_max;
  logic [11:0] cnt_inc, half;
  logic tick, hit_half, hit_sda, hit_sta, hit_sto;

  // Register port
  always_comb begin
    nxt_own = own_ff;
    nxt_rate = rate_ff;
    nxt_rdata = 8'h00;
    nxt_match = addr_valid &&
      (addr_in == own_ff[`RDS_ADR_HI:`RDS_ADR_LO]); // RL3
    if (reg_wr) begin
      case (reg_addr)
        `RDS_OFS_OWN: nxt_own = reg_wdata;
        `RDS_OFS_RATE: nxt_rate = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `RDS_OFS_OWN: nxt_rdata = own_ff;
        `RDS_OFS_RATE: nxt_rdata = rate_ff;
        `RDS_OFS_STAT: nxt_rdata = {5'h00, match_ff, sda_in,
          state_ff != S_IDLE};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      own_ff <= `RDS_OWN_RST;
      rate_ff <= `RDS_RATE_RST;
      rdata_ff <= 8'h00;
      match_ff <= 1'b0;
    end else begin
      own_ff <= nxt_own;
      rate_ff <= nxt_rate;
      rdata_ff <= nxt_rdata;
      match_ff <= nxt_match;
    end
  end

  // Rate decode and prescale tick
  always_comb begin
    rate_e = rds_lookup(rate_ff[`RDS_CODE_HI:`RDS_CODE_LO]); // RL4 RL9
    case (rate_ff[`RDS_MUL_HI:`RDS_MUL_LO]) // RL12
      `RDS_MUL_X2: pre_max = `RDS_PRE_X2;
      `RDS_MUL_X4: pre_max = `RDS_PRE_X4;
      default: pre_max = `RDS_PRE_X1;
    endcase
    tick = (pre_ff == pre_max); // RL5
    cnt_inc = cnt_ff + `RDS_CNT_ONE;
    half = {1'b0, rate_e.div[11:1]}; // RL5
    hit_half = tick && (cnt_inc == half);
    hit_sda = tick && (cnt_inc == {2'b00, rate_e.sda_hold}); // RL6
    hit_sta = tick && (cnt_inc == {1'b0, rate_e.start_hold}); // RL7
    hit_sto = tick && (cnt_inc == {1'b0, rate_e.stop_hold}); // RL8
  end

  // Line sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_pre = (state_ff == S_IDLE || tick) ? `RDS_PRE_ZERO :
      pre_ff + `RDS_PRE_ONE;
    nxt_cnt = tick ? cnt_inc : cnt_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_bit = bit_ff;
    nxt_rx = rx_ff;
    nxt_done = 1'b0;
    case (state_ff)
      S_IDLE: begin
        nxt_cnt = `RDS_CNT_ZERO;
        if (cmd_valid && scl_oe_ff) begin
          if (pre_max == `RDS_PRE_X1) nxt_cnt = `RDS_CNT_ONE; // RL6
          else nxt_pre = `RDS_PRE_ONE; // RL6
        end
        if (cmd_valid) begin
          case (cmd)
            RDS_CMD_START: begin
              if (scl_oe_ff) nxt_state = S_RS_LO;
              else begin
                nxt_state = S_ST_HOLD;
                nxt_sda_oe = 1'b1; // RL7
              end
            end
            RDS_CMD_BIT: begin
              nxt_state = S_BIT_LO;
              nxt_bit = cmd_bit;
              nxt_scl_oe = 1'b1;
            end
            RDS_CMD_STOP: begin
              nxt_state = S_SP_LO;
              nxt_scl_oe = 1'b1;
            end
            default: ;
          endcase
        end
      end
      S_RS_LO: begin
        if (hit_sda) nxt_sda_oe = 1'b0; // RL6
        if (hit_half) begin
          nxt_state = S_RS_HI;
          nxt_scl_oe = 1'b0; // RL1
          nxt_cnt = `RDS_CNT_ZERO;
        end
      end
      S_RS_HI: begin
        if (!scl_in) nxt_cnt = cnt_ff;
        if (hit_half && scl_in) begin
          nxt_state = S_ST_HOLD;
          nxt_sda_oe = 1'b1; // RL7
          nxt_cnt = `RDS_CNT_ZERO;
        end
      end
      S_ST_HOLD: if (hit_sta) begin
        nxt_state = S_IDLE;
        nxt_scl_oe = 1'b1; // RL7
        nxt_done = 1'b1;
      end
      S_BIT_LO: begin
        if (hit_sda) nxt_sda_oe = !bit_ff; // RL2 RL6
        if (hit_half) begin
          nxt_state = S_BIT_HI;
          nxt_scl_oe = 1'b0; // RL1
          nxt_cnt = `RDS_CNT_ZERO;
        end
      end
      S_BIT_HI: begin
        if (!scl_in) nxt_cnt = cnt_ff; // RL1
        if (hit_half && scl_in) begin
          nxt_state = S_IDLE;
          nxt_rx = sda_in; // RL2
          nxt_scl_oe = 1'b1;
          nxt_done = 1'b1;
        end
      end
      S_SP_LO: begin
        if (hit_sda) nxt_sda_oe = 1'b1; // RL6
        if (hit_half) begin
          nxt_state = S_SP_HI;
          nxt_scl_oe = 1'b0; // RL8
          nxt_cnt = `RDS_CNT_ZERO;
        end
      end
      S_SP_HI: begin
        if (!scl_in) nxt_cnt = cnt_ff;
        if (hit_sto && scl_in) begin
          nxt_state = S_IDLE;
          nxt_sda_oe = 1'b0; // RL8
          nxt_done = 1'b1;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      pre_ff <= `RDS_PRE_ZERO;
      cnt_ff <= `RDS_CNT_ZERO;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      bit_ff <= 1'b0;
      rx_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      bit_ff <= nxt_bit;
      rx_ff <= nxt_rx;
      done_ff <= nxt_done;
    end
  end

  assign reg_rdata = rdata_ff;
  assign cmd_ready = (state_ff == S_IDLE);
  assign done = done_ff;
  assign rx_bit = rx_ff;
  assign addr_match = match_ff;
  assign scl_out = 1'b0; // RL1
  assign scl_oe = scl_oe_ff; // RL1
  assign sda_out = 1'b0; // RL2
  assign sda_oe = sda_oe_ff; // RL2

  a_match_addr: assert property (@(posedge ref_clk) disable iff (rst) // RL3
    addr_valid && addr_in == own_ff[`RDS_ADR_HI:`RDS_ADR_LO] |=> addr_match)
    else $error("address match missed");
  a_rate_read: assert property (@(posedge ref_clk) disable iff (rst) // RL4
    reg_rd && reg_addr == `RDS_OFS_RATE |=> reg_rdata == $past(rate_ff))
    else $error("rate register read wrong");
  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst) // RL5
    tick && pre_max != `RDS_PRE_X1 && state_ff != S_IDLE |=> !tick)
    else $error("prescale tick too close");
  a_hi_data_stable: assert property (@(posedge ref_clk) disable iff (rst) // RL6
    state_ff == S_BIT_HI && $past(state_ff) == S_BIT_HI |->
    $stable(sda_oe_ff))
    else $error("data moved while clock high");
  a_start_order: assert property (@(posedge ref_clk) disable iff (rst) // RL7
    state_ff == S_ST_HOLD |-> sda_oe_ff && !scl_oe_ff)
    else $error("start order wrong");
  a_stop_order: assert property (@(posedge ref_clk) disable iff (rst) // RL8
    $fell(sda_oe_ff) && $past(state_ff) == S_SP_HI |-> !scl_oe_ff)
    else $error("stop order wrong");
  a_table_first: assert property (@(posedge ref_clk) disable iff (rst) // RL9
    rate_ff[`RDS_CODE_HI:`RDS_CODE_LO] == `RDS_CODE_00 |->
    rate_e.div == `RDS_DIV_00)
    else $error("code 00 divider wrong");
  a_table_top: assert property (@(posedge ref_clk) disable iff (rst) // RL11
    rate_ff[`RDS_CODE_HI:`RDS_CODE_LO] == `RDS_CODE_3F |->
    rate_e.div == `RDS_DIV_3F)
    else $error("code 3f divider wrong");
  a_mul_four: assert property (@(posedge ref_clk) disable iff (rst) // RL12
    state_ff != S_IDLE && rate_ff[`RDS_MUL_HI:`RDS_MUL_LO] == `RDS_MUL_X4 &&
    tick |=> !tick [*3])
    else $error("multiplier four spacing wrong");
endmodule // rds_rate_addr

// file: bench/rds_peer.sv
`timescale 1ns/10ps
module rds_peer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_oe,
  input wire logic scl_line,
  input wire logic stretch_en,
  input wire logic ack_en,
  output logic peer_scl,
  output logic peer_sda
);
  logic [2:0] cnt_ff;
  logic scl_d_ff;
  logic sda_ff;
  // Stretch clock, acknowledge after clock fall
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 3'h0;
      scl_d_ff <= 1'b1;
      sda_ff <= 1'b0;
    end else begin
      cnt_ff <= scl_oe ? 3'h6 : cnt_ff - {2'h0, cnt_ff != 3'h0};
      scl_d_ff <= scl_line;
      if (scl_d_ff && !scl_line) begin
        sda_ff <= ack_en;
      end
    end
  end
  assign peer_scl = stretch_en && cnt_ff != 3'h0;
  assign peer_sda = sda_ff;
endmodule // rds_peer

// file: bench/rds_rate_addr_bench.sv
`timescale 1ns/10ps
module rds_rate_addr_bench import rds_pkg::*;;
  logic ref_clk, rst, reg_wr, reg_rd, cmd_valid, cmd_bit, addr_valid;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, own;
  rds_cmd_e cmd;
  logic cmd_ready, done, rx_bit, addr_match, scl_oe, sda_oe;
  logic [6:0] addr_in;
  logic stretch_en, ack_en, peer_scl, peer_sda, scl_line, sda_line;
  logic rd_seen, av_seen, ps, pd, po, st_flag;
  int miscompares, comparisons, seed, cyc, t_fall, t_rise, t_sf;
  logic [7:0] rd_q[$];
  logic mt_q[$];
  logic [1:0] rx_q[$];
  int st_q[$], hi_q[$], dh_q[$], sp_q[$];
  int div_t[5] = '{20, 68, 240, 448, 3840};
  int dh_t[5] = '{7, 13, 33, 65, 513};
  int sh_t[5] = '{6, 30, 118, 222, 1918};
  int ph_t[5] = '{11, 35, 121, 225, 1921};
  int mul_t[5] = '{1, 2, 4, 1, 1};
  logic [7:0] sel_t[5] = '{8'h00, 8'h4f, 8'h9f, 8'h2a, 8'h3f};
  assign scl_line = !(scl_oe || peer_scl);
  assign sda_line = !(sda_oe || peer_sda);
  rds_rate_addr dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_bit(cmd_bit), .cmd_ready(cmd_ready), .done(done),
    .rx_bit(rx_bit), .addr_valid(addr_valid), .addr_in(addr_in),
    .addr_match(addr_match), .scl_in(scl_line), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe));
  rds_peer peer (.ref_clk(ref_clk), .rst(rst), .scl_oe(scl_oe),
    .scl_line(scl_line), .stretch_en(stretch_en), .ack_en(ack_en),
    .peer_scl(peer_scl), .peer_sda(peer_sda));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chkt(input int e, input int g);
    comparisons++;
    if (g != e) begin
      miscompares++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
  endtask
  task automatic am(input logic [6:0] a, input logic e);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    addr_valid <= 1'b1;
    addr_in <= a;
    mt_q.push_back(e);
  endtask
  task idle;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    addr_valid <= 1'b0;
  endtask
  task automatic send(input rds_cmd_e c, input logic b, input logic a,
                      input logic [1:0] r);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_bit <= b;
    rx_q.push_back(r);
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    ack_en <= a;
  endtask
  task automatic run(input int i);
    int m;
    m = mul_t[i];
    stretch_en <= (i == 0);
    wr(1, sel_t[i]);
    rd(1, sel_t[i]);
    idle;
    st_q.push_back(sh_t[i] * m);
    send(RDS_CMD_START, 1'b0, 1'b0, 2'b00);
    dh_q.push_back(dh_t[i] * m);
    hi_q.push_back(div_t[i] / 2 * m);
    send(RDS_CMD_BIT, 1'b1, 1'b1, 2'b11);
    hi_q.push_back(div_t[i] / 2 * m);
    send(RDS_CMD_BIT, 1'b1, 1'b0, 2'b10);
    dh_q.push_back(dh_t[i] * m);
    hi_q.push_back(div_t[i] / 2 * m);
    send(RDS_CMD_BIT, 1'b0, 1'b0, 2'b10);
    dh_q.push_back(dh_t[i] * m);
    st_q.push_back(sh_t[i] * m);
    send(RDS_CMD_START, 1'b0, 1'b0, 2'b00);
    sp_q.push_back(ph_t[i] * m);
    send(RDS_CMD_STOP, 1'b0, 1'b0, 2'b00);
    cmd_valid <= 1'b0;
    while (rx_q.size() != 0) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin : tmo
    if (cyc > 80000) begin
      miscompares++;
      wrap_up;
    end
  end
  always @(negedge ref_clk) begin : mon
    logic [1:0] r;
    cyc++;
    if (rd_seen) chk8(rd_q.pop_front(), reg_rdata);
    if (av_seen) chk1(mt_q.pop_front(), addr_match);
    rd_seen = reg_rd;
    av_seen = addr_valid;
    if (done === 1'b1 && rx_q.size() > 0) begin
      r = rx_q.pop_front();
      if (r[1]) chk1(r[0], rx_bit);
    end
    if (ps && !scl_line) begin
      if (st_flag) chkt(st_q.pop_front(), cyc - t_sf);
      else chkt(hi_q.pop_front(), cyc - t_rise);
      t_fall = cyc;
      st_flag = 1'b0;
    end
    if (!ps && scl_line) t_rise = cyc;
    if (ps && scl_line && pd && !sda_line) begin
      st_flag = 1'b1;
      t_sf = cyc;
    end
    if (ps && scl_line && !pd && sda_line)
      chkt(sp_q.pop_front(), cyc - t_rise);
    if (!ps && !scl_line && po !== sda_oe)
      chkt(dh_q.pop_front(), cyc - t_fall);
    ps = scl_line;
    pd = sda_line;
    po = sda_oe;
  end
  initial begin
    seed = 6288;
    {miscompares, comparisons, cyc, t_fall, t_rise, t_sf} = '0;
    {ps, pd, po, st_flag, rd_seen, av_seen} = 6'b110000;
    {rst, reg_wr, reg_rd, cmd_valid, cmd_bit, addr_valid} = 6'b100000;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    addr_in = 7'h00;
    cmd = RDS_CMD_NONE;
    stretch_en = 1'b1;
    ack_en = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(0, 8'h00);
    rd(1, 8'h00);
    own = 8'($random(seed));
    wr(0, own);
    wr(2, 8'hff);
    wr(3, 8'hff);
    rd(0, own);
    rd(2, 8'h02);
    rd(3, 8'h00);
    am(own[7:1], 1'b1);
    am(own[7:1] ^ (7'($random(seed)) | 7'h01), 1'b0);
    idle;
    for (int i = 0; i < 5; i++) begin
      run(i);
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(2'h1, 8'h00);
    rd(2'h0, 8'h00);
    idle;
    @(posedge ref_clk);
    wrap_up;
  end
endmodule // rds_rate_addr_bench
